// ---- inc/xcsd_map.vh ----
// Register map, field positions and reset values of the chip select decoder
`ifndef XCSD_MAP_VH
`define XCSD_MAP_VH

// **********************************************************************
// Register indices; byte address is four times the index
// **********************************************************************
`define XCSD_IDX_CS0_HIGH 8'h60
`define XCSD_IDX_CS0_LOW 8'h61
`define XCSD_IDX_CS1_HIGH 8'h62
`define XCSD_IDX_CS1_LOW 8'h63
`define XCSD_IDX_CTRL 8'h70
`define XCSD_ADDR_LSB 2
`define XCSD_IDX_W 8

// **********************************************************************
// Field positions
// **********************************************************************
`define XCSD_LOW_WP 1
`define XCSD_LOW_DIS 0
`define XCSD_CTRL_MODE 0
`define XCSD_CTRL_SOFTRST 1

// **********************************************************************
// Reset values
// **********************************************************************
`define XCSD_BASE_RST 8'h00
`define XCSD_CTRL_RST 8'h00

`endif

// ---- src/xcsd_cs_match.v ----
// One chip select: compares the host I/O address against a programmed base
`timescale 1ns/1ps
module xcsd_cs_match (
  input wire clk,
  input wire rst,
  input wire [7:0] baseHigh,
  input wire [7:0] baseLow,
  input wire mode2,
  input wire [15:0] ioAddr,
  input wire ioValid,
  output reg selectN
);
`include "xcsd_map.vh"

  wire hiMatch;
  wire midMatch;
  wire lowMatch;
  wire hit;

  assign hiMatch = (ioAddr[15:8] == baseHigh);
  assign midMatch = (ioAddr[7:4] == baseLow[7:4]);
  // Mode 2 decodes on 16-byte windows, bits 3:2 of the base are ignored
  assign lowMatch = mode2 | (ioAddr[3:2] == baseLow[3:2]); // see RQ4
  assign hit = ioValid & ~baseLow[`XCSD_LOW_DIS] & hiMatch & midMatch &
    lowMatch; // see RQ10

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      selectN <= 1'b1;
    end else begin
      selectN <= ~hit; // see RQ7
    end
  end

endmodule // xcsd_cs_match

// ---- src/xcsd_top.v ----
// Chip select base registers behind an AHB-Lite slave, with two decoders
//
// Summary of operation
// RQ1 - Index 0x60 holds address bits 15:8 of the chip select 0 base.
// RQ2 - Software keeps base address bits 15:12 at zero for 16-bit decode.
// RQ3 - Index 0x61 holds the low byte of the chip select 0 base.
// RQ4 - Low byte bits 7:2 are address 7:2 in mode 1, bits 7:4 in mode 2.
// RQ5 - While bit 1 of index 0x61 is set, indices 0x60 and 0x61 are locked; here a soft reset still clears all but bit 1.
// RQ6 - That lock bit clears only on hard reset; writing zero leaves it.
// RQ7 - Bit 0 of index 0x61 set disables chip select 0, clear enables it.
// RQ8 - Index 0x62 holds chip select 1 bits 15:8, locked by its own lock; here a soft reset still clears it.
// RQ9 - Index 0x63 holds the chip select 1 low byte, lock and disable bits.
// RQ10 - A chip select asserts only when enabled and all used bits match.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module xcsd_top (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [15:0] ioAddr,
  input wire ioValid,
  output reg extSelect0N,
  output reg extSelect1N
);
`include "xcsd_map.vh"

  // ********************************************************************
  // Register state
  // ********************************************************************
  reg [7:0] cs0High_q;
  reg [7:0] cs0High_d;
  reg [7:0] cs0Low_q;
  reg [7:0] cs0Low_d;
  reg [7:0] cs1High_q;
  reg [7:0] cs1High_d;
  reg [7:0] cs1Low_q;
  reg [7:0] cs1Low_d;
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg softRst_q;
  reg softRst_d;

  // ********************************************************************
  // AHB-Lite address phase capture
  // ********************************************************************
  reg wrPend_q;
  reg [7:0] wrIdx_q;
  wire take;
  wire [7:0] reqIdx;
  wire [7:0] wdata;
  wire wp0;
  wire wp1;

  // Only whole-word transfers are expected; hsize is not checked
  assign take = hsel & htrans[1] & hready;
  assign reqIdx = haddr[`XCSD_ADDR_LSB + `XCSD_IDX_W - 1:`XCSD_ADDR_LSB];
  assign wdata = hwdata[7:0];
  assign wp0 = cs0Low_q[`XCSD_LOW_WP];
  assign wp1 = cs1Low_q[`XCSD_LOW_WP];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
    end else begin
      wrPend_q <= take & hwrite;
      if (take) begin
        wrIdx_q <= reqIdx;
      end
    end
  end

  // ********************************************************************
  // Next register values
  // ********************************************************************
  always @* begin
    cs0High_d = cs0High_q;
    cs0Low_d = cs0Low_q;
    cs1High_d = cs1High_q;
    cs1Low_d = cs1Low_q;
    ctrl_d = ctrl_q;
    softRst_d = 1'b0;
    if (wrPend_q) begin
      case (wrIdx_q)
        `XCSD_IDX_CS0_HIGH: begin
          if (!wp0) begin
            cs0High_d = wdata; // see RQ1, RQ5
          end
        end
        `XCSD_IDX_CS0_LOW: begin
          if (!wp0) begin
            // Lock bit can only be set here, never cleared
            cs0Low_d = {wdata[7:2], wdata[1] | wp0, wdata[0]}; // see RQ3
          end
        end
        `XCSD_IDX_CS1_HIGH: begin
          if (!wp1) begin
            cs1High_d = wdata; // see RQ8
          end
        end
        `XCSD_IDX_CS1_LOW: begin
          if (!wp1) begin
            cs1Low_d = {wdata[7:2], wdata[1] | wp1, wdata[0]}; // see RQ9
          end
        end
        `XCSD_IDX_CTRL: begin
          ctrl_d = {7'h00, wdata[`XCSD_CTRL_MODE]};
          softRst_d = wdata[`XCSD_CTRL_SOFTRST];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    // Soft reset clears the bases even when locked, but keeps the locks
    if (softRst_q) begin
      cs0High_d = `XCSD_BASE_RST;
      cs1High_d = `XCSD_BASE_RST;
      // Bit 1 survives a soft reset; only a hard reset may unlock
      cs0Low_d = {6'h00, cs0Low_q[`XCSD_LOW_WP], 1'b0} |
        `XCSD_BASE_RST; // see RQ6
      cs1Low_d = {6'h00, cs1Low_q[`XCSD_LOW_WP], 1'b0} |
        `XCSD_BASE_RST; // see RQ9
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // Hard reset is the only path that drops the locks
      cs0High_q <= `XCSD_BASE_RST;
      cs0Low_q <= `XCSD_BASE_RST; // see RQ6
      cs1High_q <= `XCSD_BASE_RST;
      cs1Low_q <= `XCSD_BASE_RST;
      ctrl_q <= `XCSD_CTRL_RST;
      softRst_q <= 1'b0;
    end else begin
      cs0High_q <= cs0High_d;
      cs0Low_q <= cs0Low_d;
      cs1High_q <= cs1High_d;
      cs1Low_q <= cs1Low_d;
      ctrl_q <= ctrl_d;
      softRst_q <= softRst_d;
    end
  end

  // ********************************************************************
  // Read data, taken from next values so a read right after a write
  // sees the written byte
  // ********************************************************************
  reg [7:0] rdByte;

  always @* begin
    case (reqIdx)
      `XCSD_IDX_CS0_HIGH: rdByte = cs0High_d;
      `XCSD_IDX_CS0_LOW: rdByte = cs0Low_d;
      `XCSD_IDX_CS1_HIGH: rdByte = cs1High_d;
      `XCSD_IDX_CS1_LOW: rdByte = cs1Low_d;
      `XCSD_IDX_CTRL: rdByte = ctrl_d;
      default: rdByte = 8'h00;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take & ~hwrite) begin
        hrdata <= {24'h000000, rdByte};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ********************************************************************
  // Decoders
  // ********************************************************************
  wire sel0N;
  wire sel1N;

  xcsd_cs_match uMatch0 (
    .clk(clk),
    .rst(rst),
    .baseHigh(cs0High_q),
    .baseLow(cs0Low_q),
    .mode2(ctrl_q[`XCSD_CTRL_MODE]),
    .ioAddr(ioAddr),
    .ioValid(ioValid),
    .selectN(sel0N)
  );

  xcsd_cs_match uMatch1 (
    .clk(clk),
    .rst(rst),
    .baseHigh(cs1High_q),
    .baseLow(cs1Low_q),
    .mode2(ctrl_q[`XCSD_CTRL_MODE]),
    .ioAddr(ioAddr),
    .ioValid(ioValid),
    .selectN(sel1N)
  );

  // Extra stage keeps the pins straight off flops in this module
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extSelect0N <= 1'b1;
      extSelect1N <= 1'b1;
    end else begin
      extSelect0N <= sel0N; // see RQ7
      extSelect1N <= sel1N; // see RQ10
    end
  end

endmodule // xcsd_top

// ---- verification/xcsd_periph.sv ----
// Behavioural peripherals that count their select strobes
`timescale 1ns/1ps
module xcsd_periph (
  input wire clk,
  input wire sel0N,
  input wire sel1N
);
  int hits0 = 0;
  int hits1 = 0;
  always @(posedge clk) begin
    if (sel0N === 1'b0) hits0 <= hits0 + 1;
    if (sel1N === 1'b0) hits1 <= hits1 + 1;
  end
endmodule // xcsd_periph

// ---- verification/xcsd_top_asserts.sv ----
// Port-level assertions for the chip select decoder
`timescale 1ns/1ps
module xcsd_top_asserts (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire ioValid,
  input wire extSelect0N,
  input wire extSelect1N
);
  wire rd = hsel && htrans[1] && !hwrite && hready;
  wire [7:0] ix = haddr[9:2];
  logic lk0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Once a read shows the lock set, it must never read back clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lk0 <= 1'b0;
    else if ($past(rd && ix == 8'h61) && hrdata[1]) lk0 <= 1'b1;
  end
  AST_RDY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  AST_HRD_UP: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above the byte lane");
  AST_HRD_IDLE: assert property (!$past(rd) |-> hrdata == 32'h00000000)
    else $error("read data outside a read data phase");
  AST_SEL0: assert property (!extSelect0N |-> $past(ioValid, 2))
    else $error("select 0 without an I/O cycle");
  AST_SEL1: assert property (!extSelect1N |-> $past(ioValid, 2))
    else $error("select 1 without an I/O cycle");
  AST_CTRL: assert property ($past(rd && ix == 8'h70) |-> hrdata[31:1] == 0)
    else $error("control register reads stray bits");
  AST_UNMAP: assert property
    ($past(rd && !(ix inside {[8'h60:8'h63], 8'h70})) |-> hrdata == 0)
    else $error("unmapped read not zero");
  AST_LOCK0: assert property
    ($past(rd && ix == 8'h61) && lk0 |-> hrdata[1])
    else $error("lock bit cleared by software");
endmodule // xcsd_top_asserts
bind xcsd_top xcsd_top_asserts i_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ioValid(ioValid),
  .extSelect0N(extSelect0N), .extSelect1N(extSelect1N));

// ---- verification/xcsd_top_bench.sv ----
// Self-checking bench of the chip select decoder
`timescale 1ns/1ps
module xcsd_top_bench;
  logic clk, rst, hsel, hwrite, ioValid, md;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] ioAddr, lf;
  wire [31:0] hrdata;
  wire hready, hresp, sel0N, sel1N;
  logic [7:0] m [0:3];
  logic [7:0] tbl [0:5] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h50};
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  xcsd_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .ioAddr(ioAddr), .ioValid(ioValid), .extSelect0N(sel0N),
    .extSelect1N(sel1N));
  xcsd_periph i_per (.clk(clk), .sel0N(sel0N), .sel1N(sel1N));
  function automatic logic [15:0] nx(input logic [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpSel(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t selects %b expected %b", $time, got, exp);
    end
  endtask
  // The top write lane carries junk: only the low byte may matter
  task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h000000, ix, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {lf[7:0], 16'h0000, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic mwr(input logic [7:0] ix, input logic [7:0] d);
    int k;
    k = ix - 8'h60;
    if (ix >= 8'h60 && ix <= 8'h63 && !m[k | 1][1]) m[k] = d;
    if (ix == 8'h70) begin
      md = d[0];
      if (d[1]) for (k = 0; k < 4; k++) m[k] &= k[0] ? 8'h02 : 8'h00;
    end
  endtask
  function automatic logic [31:0] mrd(input logic [7:0] ix);
    if (ix >= 8'h60 && ix <= 8'h63) mrd = m[ix - 8'h60];
    else mrd = (ix == 8'h70) ? md : 32'h00000000;
  endfunction
  function automatic logic hit(input int c, input logic [15:0] a);
    hit = !m[2*c+1][0] && a[15:4] == {m[2*c], m[2*c+1][7:4]}
      && (md || a[3:2] == m[2*c+1][3:2]);
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      test_done();
    end
  end
  // ********************************************************************
  // Three hard resets, each followed by reset reads and random traffic
  // ********************************************************************
  initial begin
    int p, i, c, h0, h1;
    logic [7:0] ix, d;
    lf = 16'd50070;
    {hsel, hwrite, ioValid, htrans, haddr, hwdata, ioAddr} = 0;
    hsize = 3'h2;
    for (p = 0; p < 3; p++) begin
      rst <= 1'b1;
      m = '{4{8'h00}};
      md = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 48; i++) begin
        lf = nx(lf);
        ix = (i < 6) ? tbl[i] : tbl[lf[2:0] % 6];
        d = lf[15:8];
        if (ix == 8'h60 || ix == 8'h62) d[7:4] = 4'h0;
        // Locks stick until hard reset, so set them only rarely
        if (lf[6:4] != 3'h0) d[1] = 1'b0;
        if (i >= 6 && lf[3]) begin
          xfer(1'b1, ix, d);
          mwr(ix, d);
          @(posedge clk);
        end else begin
          xfer(1'b0, ix, 8'h00);
          cmpReg(rd, mrd(ix));
        end
        c = lf[1];
        ioAddr <= lf[0] ? {m[2*c], m[2*c+1][7:2], lf[9:8]} : lf & 16'h0FFF;
        ioValid <= lf[12] | lf[0];
        repeat (3) @(posedge clk);
        cmpSel({sel1N, sel0N}, {!(ioValid && hit(1, ioAddr)),
          !(ioValid && hit(0, ioAddr))});
        h0 = i_per.hits0;
        h1 = i_per.hits1;
        @(posedge clk);
        // The peripheral counts a strobe only while its select is low
        cmpSel({i_per.hits1 != h1, i_per.hits0 != h0},
          {ioValid && hit(1, ioAddr), ioValid && hit(0, ioAddr)});
      end
    end
    test_done();
  end
endmodule // xcsd_top_bench
